//--- epcirq_pkg.sv
// Purpose: Shared constants for the external and pin-change request block.
// Assumes: Byte-wide register port of the core, data-space addressing.
// Notes: Short I/O addresses are the data-space addresses less the I/O base.
package epcirq_pkg;
    localparam logic [7:0] ADDR_GROUP_FLAGS = 8'h3B;
    localparam logic [7:0] ADDR_EXT_FLAGS = 8'h3C;
    localparam logic [7:0] ADDR_EXT_ENABLES = 8'h3D;
    localparam logic [7:0] ADDR_GROUP_ENABLES = 8'h68;
    localparam logic [7:0] ADDR_SENSE_CTRL = 8'h69;
    localparam logic [7:0] ADDR_MASK_G0 = 8'h6B;
    localparam logic [7:0] ADDR_MASK_G1 = 8'h6C;
    localparam logic [7:0] ADDR_MASK_G2 = 8'h6D;
    localparam logic [7:0] ADDR_MASK_G3 = 8'h73;
    localparam logic [7:0] IO_SPACE_BASE = 8'h20;
    localparam logic [7:0] IO_SPACE_TOP = 8'h3F;
    localparam int NUM_EXT = 3;
    localparam int NUM_GROUPS = 4;
    localparam int GROUP_PINS = 8;
    localparam int SENSE_BITS = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_ANY = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
endpackage

//--- epcirq_sense.sv
// Purpose: One external request pin: sample, edge detect and sense decode.
// Assumes: Pin is synchronous to the clock.
// Notes: The level request bypasses the sample so it works without a clock.
`timescale 1ns/10ps
module epcirq_sense (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic [1:0] sense_i,
    output logic edge_o,
    output logic low_o
);
    typedef struct packed {
        logic prev;
    } epcirq_sense_t;
    epcirq_sense_t s_q, s_d;

    // The pin is sampled once and compared with the live value.
    always_comb begin
        s_d = s_q;
        s_d.prev = pin_i;
        low_o = ~pin_i;
        case (sense_i)
            epcirq_pkg::SENSE_LOW: edge_o = 1'b0;
            epcirq_pkg::SENSE_ANY: edge_o = pin_i ^ s_q.prev;
            epcirq_pkg::SENSE_FALL: edge_o = s_q.prev & ~pin_i;
            epcirq_pkg::SENSE_RISE: edge_o = ~s_q.prev & pin_i;
            default: edge_o = 1'b0;
        endcase
    end

    // Sample register; resets to low so a high pin after reset is a rise.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

//--- epcirq_top.sv
// Functional notes
// - Two-bit sense: 00 low level, 01 any change, 10 falling, 11 rising.
// - Pin is sampled before edge detect; pulses over one clock are caught.
// - Pin request reaches core only with global enable and its mask bit.
// - Enable register bit n enables request n; bits 7:3 unused.
// - Pin activity requests even when the pin is driven as output.
// - Each pin has its own sense field; request 2 uses bits 5:4.
// - A triggering edge sets the pin's flag at its enable position.
// - Flag, mask and global enable vector the core; ack or write-one clears.
// - In low-level mode the flag always stays cleared.
// - Four group enables in bits 3:0; group n covers pins 8n+7:8n.
// - Only pins set in the group's mask can cause a group request.
// - A masked pin change sets group flag; vector needs group and global enable.
// - Group flag clears on vector ack or write-one; zero writes do nothing.
// - Flag, enable and group flag also answer at address minus 0x20.
// - Pin-change detection is combinational so it needs no running clock.
// - Edge detection needs the clock; low-level request is combinational.
// - A pin mask bit counts only while its group enable is set.
//
// Purpose: External request and pin-change request logic with register port.
// Assumes: Core register port with one-cycle write strobe; pins synchronous.
// Notes: Request outputs are levels; the core acks a vector with a pulse.
`timescale 1ns/10ps
module epcirq_top (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic WR_I,
    input wire logic [7:0] WDATA_I,
    output logic [7:0] RDATA_O,
    input wire logic GLOBAL_IE_I,
    input wire logic [2:0] EXT_PIN_I,
    input wire logic [31:0] CHANGE_PIN_I,
    input wire logic [2:0] EXT_ACK_I,
    input wire logic [3:0] GROUP_ACK_I,
    output logic [2:0] EXT_REQ_O,
    output logic [3:0] GROUP_REQ_O,
    output logic WAKE_O
);
    typedef struct packed {
        logic [5:0] sense;
        logic [2:0] ext_en;
        logic [2:0] ext_flag;
        logic [3:0] grp_en;
        logic [3:0] grp_flag;
        logic [31:0] pin_mask;
        logic [31:0] pin_prev;
        logic [7:0] rdata;
    } epcirq_state_t;
    epcirq_state_t st_q, st_d;

    logic [2:0] ext_edge;
    logic [2:0] ext_low;
    logic [2:0] ext_is_low;
    logic [3:0] grp_change;
    logic [31:0] pin_en;
    logic [7:0] eff_addr;
    logic [7:0] rd;
    logic [31:0] pin_hit;

    // One sense slice per request pin; the pin value is used regardless of
    // its port direction, which lets software raise a request itself.
    genvar gi;
    generate
        for (gi = 0; gi < epcirq_pkg::NUM_EXT; gi++) begin : g_ext
            epcirq_sense u_sense (
                .clk_i(CLOCK_I),
                .rst_n_i(RST_N_I),
                .pin_i(EXT_PIN_I[gi]),
                .sense_i(st_q.sense[gi*epcirq_pkg::SENSE_BITS +: epcirq_pkg::SENSE_BITS]),
                .edge_o(ext_edge[gi]),
                .low_o(ext_low[gi])
            );
            assign ext_is_low[gi] =
                st_q.sense[gi*epcirq_pkg::SENSE_BITS +: epcirq_pkg::SENSE_BITS]
                == epcirq_pkg::SENSE_LOW;
        end
    endgenerate

    // Pin-change detect is a compare against the last seen value, so a
    // change shows combinationally even before the clock is back.
    always_comb begin
        for (int g = 0; g < epcirq_pkg::NUM_GROUPS; g++) begin
            for (int p = 0; p < epcirq_pkg::GROUP_PINS; p++) begin
                pin_en[g*epcirq_pkg::GROUP_PINS+p] =
                    st_q.pin_mask[g*epcirq_pkg::GROUP_PINS+p] & st_q.grp_en[g];
            end
        end
        // Second pass: masked changes first, then one OR per group of eight.
        pin_hit = (CHANGE_PIN_I ^ st_q.pin_prev) & pin_en;
        for (int g = 0; g < epcirq_pkg::NUM_GROUPS; g++) begin
            grp_change[g] =
                |pin_hit[g*epcirq_pkg::GROUP_PINS +: epcirq_pkg::GROUP_PINS];
        end
    end

    // Short I/O space aliases onto the data space by adding the base back.
    always_comb begin
        if (ADDR_I <= epcirq_pkg::IO_SPACE_TOP - epcirq_pkg::IO_SPACE_BASE) begin
            eff_addr = ADDR_I + epcirq_pkg::IO_SPACE_BASE;
        end else begin
            eff_addr = ADDR_I;
        end
    end

    // Read mux; unused upper bits come back as zero.
    always_comb begin
        rd = epcirq_pkg::RESET_BYTE;
        case (eff_addr)
            epcirq_pkg::ADDR_GROUP_FLAGS: rd = {4'h0, st_q.grp_flag};
            epcirq_pkg::ADDR_EXT_FLAGS: rd = {5'h00, st_q.ext_flag};
            epcirq_pkg::ADDR_EXT_ENABLES: rd = {5'h00, st_q.ext_en};
            epcirq_pkg::ADDR_GROUP_ENABLES: rd = {4'h0, st_q.grp_en};
            epcirq_pkg::ADDR_SENSE_CTRL: rd = {2'h0, st_q.sense};
            epcirq_pkg::ADDR_MASK_G0: rd = st_q.pin_mask[7:0];
            epcirq_pkg::ADDR_MASK_G1: rd = st_q.pin_mask[15:8];
            epcirq_pkg::ADDR_MASK_G2: rd = st_q.pin_mask[23:16];
            epcirq_pkg::ADDR_MASK_G3: rd = st_q.pin_mask[31:24];
            default: rd = epcirq_pkg::RESET_BYTE;
        endcase
    end

    // Next state: writes, then clears, then hardware sets, so an event in
    // the cycle of its clear still leaves the flag set.
    always_comb begin
        st_d = st_q;
        st_d.pin_prev = CHANGE_PIN_I;
        st_d.rdata = rd; // Read data lags its address by one cycle.
        if (WR_I) begin
            case (eff_addr)
                epcirq_pkg::ADDR_EXT_ENABLES: st_d.ext_en = WDATA_I[2:0];
                epcirq_pkg::ADDR_GROUP_ENABLES: st_d.grp_en = WDATA_I[3:0];
                epcirq_pkg::ADDR_SENSE_CTRL: st_d.sense = WDATA_I[5:0];
                epcirq_pkg::ADDR_MASK_G0: st_d.pin_mask[7:0] = WDATA_I;
                epcirq_pkg::ADDR_MASK_G1: st_d.pin_mask[15:8] = WDATA_I;
                epcirq_pkg::ADDR_MASK_G2: st_d.pin_mask[23:16] = WDATA_I;
                epcirq_pkg::ADDR_MASK_G3: st_d.pin_mask[31:24] = WDATA_I;
                epcirq_pkg::ADDR_EXT_FLAGS: st_d.ext_flag = st_q.ext_flag & ~WDATA_I[2:0];
                epcirq_pkg::ADDR_GROUP_FLAGS: st_d.grp_flag = st_q.grp_flag & ~WDATA_I[3:0];
                default: st_d = st_d;
            endcase
        end
        st_d.ext_flag = st_d.ext_flag & ~EXT_ACK_I;
        st_d.grp_flag = st_d.grp_flag & ~GROUP_ACK_I;
        st_d.ext_flag = (st_d.ext_flag | ext_edge) & ~ext_is_low;
        st_d.grp_flag = st_d.grp_flag | grp_change;
    end

    // State register under synchronous reset.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Requests: level mode drives straight from the pin, edge modes from
    // the flag; both gated by the request's enable bit and the core's global enable.
    always_comb begin
        for (int i = 0; i < epcirq_pkg::NUM_EXT; i++) begin
            EXT_REQ_O[i] = GLOBAL_IE_I & st_q.ext_en[i]
                & (ext_is_low[i] ? ext_low[i] : st_q.ext_flag[i]);
        end
        GROUP_REQ_O = {4{GLOBAL_IE_I}} & st_q.grp_en & st_q.grp_flag;
        WAKE_O = (|(st_q.ext_en & ext_is_low & ext_low)) | (|grp_change);
    end

    // Read data lives in the state record, so it shows the cycle after its address.
    assign RDATA_O = st_q.rdata;

    // External flags: an edge sets a flag and nothing else can; an ack or a written
    // one clears it, but an edge in the same cycle wins so no event is lost.
    flag_edge_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ext_edge[0] && !ext_is_low[0]) |=> st_q.ext_flag[0])
        else $error("edge did not set flag");
    flag_edge_two_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ext_edge[2] && !ext_is_low[2]) |=> st_q.ext_flag[2])
        else $error("edge did not set flag two");
    flag_cause_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (!ext_edge[2] && !st_q.ext_flag[2]) |=> !st_q.ext_flag[2])
        else $error("flag two set without an edge");
    ack_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (EXT_ACK_I[0] && !ext_edge[0]) |=> !st_q.ext_flag[0])
        else $error("ack did not clear flag");
    ack_clear_two_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (EXT_ACK_I[2] && !ext_edge[2]) |=> !st_q.ext_flag[2])
        else $error("ack did not clear flag two");
    ext_w1c_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_EXT_FLAGS && WDATA_I[2] && !ext_edge[2])
        |=> !st_q.ext_flag[2])
        else $error("written one did not clear flag two");
    ext_keep_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_EXT_FLAGS && !WDATA_I[2] && !EXT_ACK_I[2]
         && st_q.ext_flag[2] && !ext_is_low[2]) |=> st_q.ext_flag[2])
        else $error("zero write cleared flag two");

    // Level mode: the flag stays clear and the live pin drives request and wake,
    // which is what lets a held low level rouse a part whose clock is stopped.
    low_flag_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        ext_is_low[1] |=> (!st_q.ext_flag[1] || !ext_is_low[1]))
        else $error("flag set in level mode");
    low_flag_zero_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        ext_is_low[0] |=> !st_q.ext_flag[0])
        else $error("flag zero set in level mode");
    low_flag_two_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        ext_is_low[2] |=> !st_q.ext_flag[2])
        else $error("flag two set in level mode");
    level_req_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ext_is_low[0] && st_q.ext_en[0] && GLOBAL_IE_I && !EXT_PIN_I[0])
        |-> EXT_REQ_O[0])
        else $error("low level gave no request");
    level_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ext_is_low[0] && EXT_PIN_I[0]) |-> !EXT_REQ_O[0])
        else $error("high level gave a request");
    level_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ext_is_low[0] && st_q.ext_en[0] && !EXT_PIN_I[0]) |-> WAKE_O)
        else $error("low level gave no wake");

    // Sense decode of request two against the sampled pin; the reset guard keeps a
    // pin that stood high through reset from looking like a missed fall.
    rise_sense_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (st_q.sense[5:4] == epcirq_pkg::SENSE_RISE && $past(RST_N_I)
         && $rose(EXT_PIN_I[2])) |-> ext_edge[2])
        else $error("rising edge missed");
    fall_sense_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (st_q.sense[5:4] == epcirq_pkg::SENSE_FALL && $past(RST_N_I)
         && $fell(EXT_PIN_I[2])) |-> ext_edge[2])
        else $error("falling edge missed");
    any_sense_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (st_q.sense[5:4] == epcirq_pkg::SENSE_ANY && $past(RST_N_I)
         && $changed(EXT_PIN_I[2])) |-> ext_edge[2])
        else $error("pin change missed");
    sense_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_SENSE_CTRL)
        |=> st_q.sense[5:4] == $past(WDATA_I[5:4]))
        else $error("sense field two not written");

    // Request gating and the enable register: nothing reaches the core while the
    // global enable is clear, and a pending flag goes out once both enables are set.
    req_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        EXT_REQ_O[2] |-> (GLOBAL_IE_I && st_q.ext_en[2]))
        else $error("request without enables");
    edge_req_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (!ext_is_low[2] && st_q.ext_flag[2] && st_q.ext_en[2] && GLOBAL_IE_I)
        |-> EXT_REQ_O[2])
        else $error("pending flag gave no request");
    ie_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !GLOBAL_IE_I |-> (EXT_REQ_O == 3'h0 && GROUP_REQ_O == 4'h0))
        else $error("request with global enable clear");
    en_write_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_EXT_ENABLES)
        |=> st_q.ext_en == $past(WDATA_I[2:0]))
        else $error("enable register not written");

    // Pin-change groups: a masked change in an enabled group sets the group flag,
    // an ack or a written one clears it, and a written zero leaves it alone.
    grp_set_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        grp_change[3] |=> st_q.grp_flag[3])
        else $error("group change lost");
    grp_cause_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (!grp_change[3] && !st_q.grp_flag[3]) |=> !st_q.grp_flag[3])
        else $error("group flag set without a change");
    pin_hit_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (st_q.pin_mask[24] && st_q.grp_en[3] && CHANGE_PIN_I[24] != st_q.pin_prev[24])
        |-> grp_change[3])
        else $error("enabled pin change missed");
    grp_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (CHANGE_PIN_I[31:24] == st_q.pin_prev[31:24]) |-> !grp_change[3])
        else $error("group change without a pin change");
    grp_w1c_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_GROUP_FLAGS && !WDATA_I[3]
         && !GROUP_ACK_I[3] && st_q.grp_flag[3]) |=> st_q.grp_flag[3])
        else $error("zero write cleared group flag");
    grp_clear_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_GROUP_FLAGS && WDATA_I[3] && !grp_change[3])
        |=> !st_q.grp_flag[3])
        else $error("written one did not clear group flag");
    grp_ack_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (GROUP_ACK_I[3] && !grp_change[3]) |=> !st_q.grp_flag[3])
        else $error("ack did not clear group flag");
    mask_off_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        !st_q.grp_en[0] |-> !grp_change[0])
        else $error("disabled group saw change");
    grp_enable_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (WR_I && eff_addr == epcirq_pkg::ADDR_GROUP_ENABLES)
        |=> st_q.grp_en == $past(WDATA_I[3:0]))
        else $error("group enables not written");
    grp_req_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        GROUP_REQ_O[2] |-> (st_q.grp_flag[2] && st_q.grp_en[2] && GLOBAL_IE_I))
        else $error("group request without cause");
    grp_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        grp_change[3] |-> WAKE_O)
        else $error("group change gave no wake");

    // Register port: unused bits read zero, the short I/O space aliases onto the
    // data space, and addresses above that space pass through untouched.
    unused_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (!WR_I && $past(eff_addr) == epcirq_pkg::ADDR_EXT_ENABLES) |-> RDATA_O[7:3] == 5'h00)
        else $error("unused bits read nonzero");
    grp_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ADDR_I == epcirq_pkg::ADDR_GROUP_ENABLES)
        |=> RDATA_O == {4'h0, $past(st_q.grp_en)})
        else $error("group enables read wrong");
    alias_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ADDR_I == epcirq_pkg::ADDR_EXT_ENABLES - epcirq_pkg::IO_SPACE_BASE)
        |-> eff_addr == epcirq_pkg::ADDR_EXT_ENABLES)
        else $error("io alias wrong");
    alias_flag_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ADDR_I == epcirq_pkg::ADDR_EXT_FLAGS - epcirq_pkg::IO_SPACE_BASE)
        |-> eff_addr == epcirq_pkg::ADDR_EXT_FLAGS)
        else $error("io alias of flags wrong");
    data_space_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ADDR_I > epcirq_pkg::IO_SPACE_TOP - epcirq_pkg::IO_SPACE_BASE)
        |-> eff_addr == ADDR_I)
        else $error("data space address moved");
endmodule

//--- epcirq_core_model.sv
// Purpose: Behavioural model of the core's vector dispatch for the request block.
// Assumes: Requests are levels; an ack is a one-cycle pulse driven at the falling edge.
// Notes: It never acks two cycles running, so a request that drops after its ack yields exactly one ack; a held level is acked every other cycle.
`timescale 1ns/10ps
module epcirq_core_model (
    input wire logic clk_i,
    input wire logic global_ie_i,
    input wire logic [2:0] ext_req_i,
    input wire logic [3:0] group_req_i,
    output logic [2:0] ext_ack_o,
    output logic [3:0] group_ack_o
);
    logic [2:0] ext_ack_q = 3'h0;
    logic [3:0] group_ack_q = 4'h0;
    // Take a vector for each pending request while the global enable is set.
    always @(negedge clk_i) begin
        ext_ack_q <= ext_req_i & ~ext_ack_q & {3{global_ie_i}};
        group_ack_q <= group_req_i & ~group_ack_q & {4{global_ie_i}};
    end
    assign ext_ack_o = ext_ack_q;
    assign group_ack_o = group_ack_q;
endmodule

//--- external_pin_change_irq_bench.sv
// Purpose: Self-checking bench for the external and pin-change request block.
// Assumes: Inputs change at the falling edge; read data lags the address by one cycle.
// Notes: Pins stay low through reset so the edge samplers start without a false edge.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module external_pin_change_irq_bench;
    logic CLOCK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [7:0] ADDR_I = 8'h00;
    logic WR_I = 1'b0;
    logic [7:0] WDATA_I = 8'h00;
    logic GLOBAL_IE_I = 1'b0;
    logic [2:0] EXT_PIN_I = 3'h0;
    logic [31:0] CHANGE_PIN_I = 32'h0;
    logic [7:0] RDATA_O;
    logic [2:0] EXT_ACK_I, EXT_REQ_O;
    logic [3:0] GROUP_ACK_I, GROUP_REQ_O;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int acks = 0;
    logic [7:0] reset_regs [4] = '{8'h3B, 8'h3C, 8'h3D, 8'h68};
    logic WAKE_O;
    epcirq_top dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I),
        .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .GLOBAL_IE_I(GLOBAL_IE_I),
        .EXT_PIN_I(EXT_PIN_I), .CHANGE_PIN_I(CHANGE_PIN_I), .EXT_ACK_I(EXT_ACK_I),
        .GROUP_ACK_I(GROUP_ACK_I), .EXT_REQ_O(EXT_REQ_O), .GROUP_REQ_O(GROUP_REQ_O),
        .WAKE_O(WAKE_O));
    epcirq_core_model core (.clk_i(CLOCK_I), .global_ie_i(GLOBAL_IE_I),
        .ext_req_i(EXT_REQ_O), .group_req_i(GROUP_REQ_O), .ext_ack_o(EXT_ACK_I),
        .group_ack_o(GROUP_ACK_I));
    // A 40 ns clock.
    always #20 CLOCK_I = ~CLOCK_I;
    // Count cycles and vectors taken for request two; a hang ends the run as a failure.
    always @(posedge CLOCK_I) begin
        cycles++;
        if (EXT_ACK_I[2] === 1'b1) acks++;
        if (cycles == 4000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLOCK_I);
        ADDR_I = a;
        WR_I = 1'b1;
        WDATA_I = d;
        @(negedge CLOCK_I);
        WR_I = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLOCK_I);
        ADDR_I = a;
        @(negedge CLOCK_I);
        `CHK($sformatf("register %h", a), e, RDATA_O)
    endtask
    // Each pin level is held two cycles, longer than the one-clock minimum pulse.
    task automatic pin(input int i, input logic v);
        @(negedge CLOCK_I);
        EXT_PIN_I[i] = v;
        repeat (2) @(negedge CLOCK_I);
    endtask
    task automatic chg(input int i);
        @(negedge CLOCK_I);
        CHANGE_PIN_I[i] = ~CHANGE_PIN_I[i];
        repeat (2) @(negedge CLOCK_I);
    endtask
    // Main sequence: reset, registers, edge modes, vectors, level mode, pin change.
    initial begin
        repeat (10) @(negedge CLOCK_I);
        RST_N_I = 1'b1;
        foreach (reset_regs[k]) rd(reset_regs[k], 8'h00);
        $display("test reset done");
        wr(8'h3D, 8'hFF);
        rd(8'h3D, 8'h07);
        rd(8'h1D, 8'h07);
        wr(8'h68, 8'hFF);
        rd(8'h68, 8'h0F);
        wr(8'h1D, 8'h00);
        rd(8'h3D, 8'h00);
        $display("test registers done");
        for (int c = 1; c < 4; c++) begin
            wr(8'h69, 8'(c << 4));
            wr(8'h3C, 8'h07);
            pin(2, 1'b1);
            rd(8'h3C, (c != 2) ? 8'h04 : 8'h00);
            wr(8'h3C, 8'h07);
            pin(2, 1'b0);
            rd(8'h1C, (c != 3) ? 8'h04 : 8'h00);
        end
        wr(8'h3C, 8'h07);
        $display("test edge modes done");
        wr(8'h69, 8'h20);
        wr(8'h3D, 8'h04);
        GLOBAL_IE_I = 1'b1;
        pin(2, 1'b1);
        pin(2, 1'b0);
        repeat (4) @(negedge CLOCK_I);
        `CHK("vectors taken", 1, acks)
        rd(8'h3C, 8'h00);
        `CHK("request after ack", 3'h0, EXT_REQ_O)
        $display("test vector done");
        GLOBAL_IE_I = 1'b0;
        wr(8'h69, 8'h00);
        wr(8'h3D, 8'h01);
        `CHK("level request masked", 3'h0, EXT_REQ_O)
        GLOBAL_IE_I = 1'b1;
        @(negedge CLOCK_I);
        `CHK("level request", 3'h1, EXT_REQ_O)
        `CHK("level wake", 1'b1, WAKE_O)
        rd(8'h3C, 8'h00);
        pin(0, 1'b1);
        `CHK("level released", 3'h0, EXT_REQ_O)
        `CHK("wake released", 1'b0, WAKE_O)
        GLOBAL_IE_I = 1'b0;
        $display("test level done");
        wr(8'h73, 8'h01);
        wr(8'h68, 8'h00);
        chg(24);
        rd(8'h3B, 8'h00);
        wr(8'h68, 8'h08);
        chg(25);
        rd(8'h3B, 8'h00);
        chg(24);
        rd(8'h3B, 8'h08);
        wr(8'h3B, 8'h00);
        rd(8'h1B, 8'h08);
        wr(8'h1B, 8'h08);
        rd(8'h3B, 8'h00);
        chg(24);
        `CHK("group request masked", 4'h0, GROUP_REQ_O)
        GLOBAL_IE_I = 1'b1;
        #1 `CHK("group request", 4'h8, GROUP_REQ_O)
        repeat (3) @(negedge CLOCK_I);
        rd(8'h3B, 8'h00);
        `CHK("group request after ack", 4'h0, GROUP_REQ_O)
        GLOBAL_IE_I = 1'b0;
        $display("test pin change done");
        test_done();
    end
endmodule
